// file: inc/sdram_fetch_pkg.sv
// Constants, types and decode functions of the instruction fetch sequencer
package sdram_fetch_pkg;

  // Controller cycle is two processor cycles
  localparam int MPU_PER_TC = 2;

  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int ADDR_W = ROW_W + COL_W;
  localparam int DQ_W = 16;
  localparam int LINE_WORDS = 8;
  localparam int LINE_W = DQ_W * LINE_WORDS;
  localparam int IDX_W = 3;
  localparam int NW_W = 4;
  localparam int HIT_W = 32;
  localparam int CNT_W = 5;
  localparam int STAT_W = 16;

  // Command spacing in controller cycles
  localparam logic [CNT_W-1:0] CAS_LAT_TC = 5'h02;
  localparam logic [CNT_W-1:0] RAS_TO_CAS_TC = 5'h03;
  // Sampled data trails the pins by one controller cycle
  localparam logic [CNT_W-1:0] SYNC_TC = 5'h01;
  localparam logic [CNT_W-1:0] CAP_FIRST_TC = CAS_LAT_TC + SYNC_TC;

  // Halfwords per burst; the terminating strobe follows at the same count
  localparam logic [NW_W-1:0] FILL_WORDS = 4'h8;
  localparam logic [NW_W-1:0] WORD32_WORDS = 4'h2;
  localparam logic [NW_W-1:0] HALF16_WORDS = 4'h1;

  // Gap from last latch to next column command, in processor cycles
  localparam int GAP_32_MPU = 10;
  localparam int GAP_16_MPU = 12;
  localparam logic [CNT_W-1:0] GAP_32_TC = CNT_W'(GAP_32_MPU / MPU_PER_TC);
  localparam logic [CNT_W-1:0] GAP_16_TC = CNT_W'(GAP_16_MPU / MPU_PER_TC);

  typedef enum logic [2:0] {
    FETCH_HIT,
    FETCH_FILL32,
    FETCH_FILL16,
    FETCH_WORD32,
    FETCH_HALF16
  } fetch_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    fetch_e kind;
    logic [HIT_W-1:0] hit_data;
  } req_s;

  typedef struct packed {
    logic [LINE_W-1:0] data;
    logic [NW_W-1:0] nwords;
    logic hit;
  } rsp_s;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [ROW_W-1:0] addr;
  } sd_cmd_s;

  function automatic logic [NW_W-1:0] burst_words(input fetch_e kind);
    case (kind)
      FETCH_FILL32, FETCH_FILL16: burst_words = FILL_WORDS;
      FETCH_WORD32: burst_words = WORD32_WORDS;
      FETCH_HALF16: burst_words = HALF16_WORDS;
      default: burst_words = HALF16_WORDS;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] gap_tc(input fetch_e kind);
    case (kind)
      FETCH_FILL32, FETCH_WORD32: gap_tc = GAP_32_TC;
      default: gap_tc = GAP_16_TC;
    endcase
  endfunction

endpackage

// file: rtl/tc_tick.sv
// Controller cycle tick and memory clock derived from the processor clock
`timescale 1ns/1ps
module tc_tick
  import sdram_fetch_pkg::*;
#(
  parameter int DIV = MPU_PER_TC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic tc_edge,
  output logic sd_clk
);

  localparam logic [3:0] LAST = 4'(DIV - 1);
  localparam logic [3:0] HALF = 4'(DIV / 2);

  logic [3:0] cnt_r;
  logic sd_clk_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= 4'h0;
    end else if (cnt_r == LAST) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Memory clock rises at each controller cycle boundary
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sd_clk_r <= 1'b0;
    end else begin
      sd_clk_r <= (cnt_r == LAST) || (cnt_r < HALF - 4'h1);
    end
  end

  assign tc_edge = (cnt_r == LAST);
  assign sd_clk = sd_clk_r;

endmodule

// file: rtl/sdram_fetch_seq.sv
// Instruction fetch read burst sequencer toward the external SDRAM
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - Line fill: write-enable strobe eight controller cycles after column read.
// - Burst stops two cycles after the terminating strobe, column latency 2.
// - A line fill returns exactly eight halfwords, one full cache line.
// - Line fill: last halfword latched two cycles after terminating strobe.
// - 32-bit line fill: five controller cycles from last latch to next column read.
// - Cached fetches pay the read gap once per line, not per instruction.
// - Uncached 32-bit fetch: ten processor cycle gap before next read.
// - Row strobe first, column strobe three controller cycles later.
// - Uncached 16-bit: terminating strobe one cycle after column read.
// - Uncached 16-bit: one halfword, on the bus a cycle after strobe.
// - Uncached 16-bit: halfword latched two cycles after the strobe.
// - Uncached 16-bit: six controller cycles to next column read.
// - Cache hit answers in one processor cycle, no memory access.
// - 16-bit line fill takes one controller cycle more than 32-bit.
// - A burst yields one new word every controller cycle until stopped.
// - Uncached 32-bit: strobe two cycles after column, two halfwords.
////////////////////////////////////////////////////////////////////////////
module sdram_fetch_seq
  import sdram_fetch_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input req_s req,
  output logic rsp_valid,
  output rsp_s rsp,
  output logic word_valid,
  output logic [DQ_W-1:0] word_data,
  output logic busy,
  output logic [STAT_W-1:0] fill_count,
  output logic [STAT_W-1:0] hit_count,
  output logic sd_clk,
  output sd_cmd_s sd_cmd,
  input wire logic [DQ_W-1:0] sd_dq_in
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACT,
    ST_BURST,
    ST_GAP
  } state_e;

  state_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] gap_r;
  fetch_e kind_r;
  logic [COL_W-1:0] col_r;
  logic [NW_W-1:0] nwords_r;
  logic [DQ_W-1:0] dq_meta_r;
  logic [DQ_W-1:0] dq_sync_r;
  logic [DQ_W-1:0] buf_r [LINE_WORDS];
  sd_cmd_s cmd_r;
  rsp_s rsp_r;
  logic rsp_valid_r;
  logic word_valid_r;
  logic [DQ_W-1:0] word_data_r;
  logic [STAT_W-1:0] fill_cnt_r;
  logic [STAT_W-1:0] hit_cnt_r;
  logic tc_edge;
  logic tc_late_r;
  logic is_hit;
  logic can_start;
  logic take;
  logic start_ext;
  logic cas_now;
  logic term_now;
  logic cap_any;
  logic cap_last;
  logic [CNT_W-1:0] cap_ofs;
  logic [IDX_W-1:0] cap_idx;
  logic [LINE_W-1:0] line_c;

  ////////////////////////////////////////////////////////////////////////////
  // Controller cycle timing

  tc_tick #(
    .DIV(MPU_PER_TC)
  ) u_tick (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tc_edge(tc_edge),
    .sd_clk(sd_clk)
  );

  // Marks the clock after each controller cycle tick
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tc_late_r <= 1'b0;
    end else begin
      tc_late_r <= tc_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request acceptance and sequence points

  assign is_hit = (req.kind == FETCH_HIT);
  // Next row open may overlap the tail of the gap
  assign can_start = (state_r == ST_IDLE) ||
                     ((state_r == ST_GAP) && (gap_r == 5'h01));
  // Hits wait for ST_IDLE and skip the controller cycle wait
  assign req_ready = ((state_r == ST_IDLE) && is_hit) ||
                     (can_start && tc_edge && !is_hit);
  assign take = req_valid && req_ready;
  assign start_ext = take && !is_hit;
  assign cnt_nxt = cnt_r + 5'h01;

  assign cas_now = (state_r == ST_ACT) && tc_edge &&
                   (cnt_nxt == RAS_TO_CAS_TC);
  // Burst length in halfwords equals the strobe delay after column read
  assign term_now = (state_r == ST_BURST) && tc_edge &&
                    (cnt_nxt == CNT_W'(nwords_r));
  // First word at column latency, seen one cycle later past the sync
  // Both sync stages hold the word only on the clock after the tick,
  // so latching happens there, still inside the same controller cycle
  assign cap_ofs = cnt_r - CAP_FIRST_TC;
  assign cap_idx = cap_ofs[IDX_W-1:0];
  assign cap_any = (state_r == ST_BURST) && tc_late_r &&
                   (cnt_r >= CAP_FIRST_TC) &&
                   (cap_ofs < CNT_W'(nwords_r));
  // Last word lands two cycles after the terminating strobe
  assign cap_last = cap_any &&
                    (cap_ofs == CNT_W'(nwords_r) - 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      gap_r <= 5'h00;
      kind_r <= FETCH_HIT;
      col_r <= '0;
      nwords_r <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE, ST_GAP: begin
          if (start_ext) begin
            state_r <= ST_ACT;
            cnt_r <= 5'h00;
            kind_r <= req.kind;
            col_r <= req.addr[COL_W-1:0];
            nwords_r <= burst_words(req.kind);
          end else if ((state_r == ST_GAP) && tc_edge) begin
            if (gap_r == 5'h01) begin
              state_r <= ST_IDLE;
            end else begin
              gap_r <= gap_r - 5'h01;
            end
          end
        end
        ST_ACT: begin
          if (cas_now) begin
            state_r <= ST_BURST;
            cnt_r <= 5'h00;
          end else if (tc_edge) begin
            cnt_r <= cnt_nxt;
          end
        end
        ST_BURST: begin
          if (cap_last) begin
            state_r <= ST_GAP;
            // Gap counted to the next column read, row open included
            gap_r <= gap_tc(kind_r) - RAS_TO_CAS_TC;
          end else if (tc_edge) begin
            cnt_r <= cnt_nxt;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory command strobes, each low for one controller cycle

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_r.ras_n <= 1'b1;
      cmd_r.cas_n <= 1'b1;
      cmd_r.we_n <= 1'b1;
      cmd_r.addr <= '0;
    end else if (tc_edge) begin
      cmd_r.ras_n <= 1'b1;
      cmd_r.cas_n <= 1'b1;
      cmd_r.we_n <= 1'b1;
      if (start_ext) begin
        cmd_r.ras_n <= 1'b0;
        cmd_r.addr <= req.addr[ADDR_W-1:COL_W];
      end
      if (cas_now) begin
        cmd_r.cas_n <= 1'b0;
        cmd_r.addr <= {{(ROW_W - COL_W){1'b0}}, col_r};
      end
      if (term_now) begin
        cmd_r.we_n <= 1'b0;
      end
    end
  end

  assign sd_cmd = cmd_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read data synchroniser and line buffer

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dq_meta_r <= '0;
      dq_sync_r <= '0;
    end else begin
      dq_meta_r <= sd_dq_in;
      dq_sync_r <= dq_meta_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < LINE_WORDS; i++) begin
        buf_r[i] <= '0;
      end
    end else if (cap_any) begin
      buf_r[cap_idx] <= dq_sync_r;
    end
  end

  // Line image with the word latched this cycle merged in
  always_comb begin
    line_c = '0;
    for (int j = 0; j < LINE_WORDS; j++) begin
      if (NW_W'(j) < nwords_r) begin
        if (IDX_W'(j) == cap_idx) begin
          line_c[j*DQ_W +: DQ_W] = dq_sync_r;
        end else begin
          line_c[j*DQ_W +: DQ_W] = buf_r[j];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Responses: per halfword stream and completed fetch

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      word_valid_r <= 1'b0;
      word_data_r <= '0;
    end else begin
      word_valid_r <= cap_any;
      if (cap_any) begin
        word_data_r <= dq_sync_r;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      rsp_valid_r <= 1'b0;
      if (take && is_hit) begin
        rsp_valid_r <= 1'b1;
        rsp_r.data <= {{(LINE_W - HIT_W){1'b0}}, req.hit_data};
        rsp_r.nwords <= WORD32_WORDS;
        rsp_r.hit <= 1'b1;
      end else if (cap_last) begin
        rsp_valid_r <= 1'b1;
        rsp_r.data <= line_c;
        rsp_r.nwords <= nwords_r;
        rsp_r.hit <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity counters

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fill_cnt_r <= '0;
      hit_cnt_r <= '0;
    end else begin
      if (cap_last && ((kind_r == FETCH_FILL32) ||
                       (kind_r == FETCH_FILL16))) begin
        fill_cnt_r <= fill_cnt_r + 16'h0001;
      end
      if (take && is_hit) begin
        hit_cnt_r <= hit_cnt_r + 16'h0001;
      end
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign word_valid = word_valid_r;
  assign word_data = word_data_r;
  assign busy = (state_r != ST_IDLE);
  assign fill_count = fill_cnt_r;
  assign hit_count = hit_cnt_r;

endmodule

// file: bench/sdram_fetch_chk.sv
// Port assertions for the fetch sequencer
`timescale 1ns/1ps
module sdram_fetch_chk
  import sdram_fetch_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input req_s req,
  input wire logic rsp_valid,
  input rsp_s rsp,
  input sd_cmd_s sd_cmd
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  fetch_e kind_r;
  logic g16_r;
  logic [4:0] since_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      kind_r <= FETCH_HIT;
    else if (req_valid && req_ready && req.kind != FETCH_HIT)
      kind_r <= req.kind;
  end
  // Clocks since the last memory response
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      since_r <= 5'h1f;
    else if (rsp_valid && !rsp.hit)
      since_r <= 5'h01;
    else if (since_r != 5'h1f)
      since_r <= since_r + 5'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      g16_r <= 1'b0;
    else if (rsp_valid && !rsp.hit)
      g16_r <= kind_r inside {FETCH_FILL16, FETCH_HALF16};
  end
  ////////////////////////////////////////
  sequence s_pulse(sig);
    !sig ##1 !sig ##1 sig;
  endsequence
  property p_ras;
    $fell(sd_cmd.ras_n) |-> s_pulse(sd_cmd.ras_n);
  endproperty
  property p_cas;
    $fell(sd_cmd.ras_n) |-> sd_cmd.cas_n [*6] ##1 s_pulse(sd_cmd.cas_n);
  endproperty
  property p_wefill;
    $fell(sd_cmd.cas_n) && (kind_r inside {FETCH_FILL32, FETCH_FILL16})
      |-> ##16 $fell(sd_cmd.we_n);
  endproperty
  property p_we32;
    $fell(sd_cmd.cas_n) && kind_r == FETCH_WORD32 |-> ##4 $fell(sd_cmd.we_n);
  endproperty
  property p_we16;
    $fell(sd_cmd.cas_n) && kind_r == FETCH_HALF16 |-> ##2 $fell(sd_cmd.we_n);
  endproperty
  property p_last;
    $fell(sd_cmd.we_n) |-> !rsp_valid [*5] ##1 rsp_valid;
  endproperty
  property p_nw;
    rsp_valid && !rsp.hit |-> rsp.nwords == (kind_r == FETCH_WORD32 ? 4'h2 :
      kind_r == FETCH_HALF16 ? 4'h1 : 4'h8);
  endproperty
  property p_gap;
    $fell(sd_cmd.cas_n) |-> since_r >= (g16_r ? 5'h0b : 5'h09);
  endproperty
  property p_hit;
    req_valid && req_ready && req.kind == FETCH_HIT |=> rsp_valid &&
      rsp.hit && rsp.data[31:0] == $past(req.hit_data) && sd_cmd.ras_n;
  endproperty
  a_ras: assert property (p_ras) else $error("row strobe width");
  a_cas: assert property (p_cas) else $error("row to column");
  a_wefill: assert property (p_wefill) else $error("fill stop");
  a_we32: assert property (p_we32) else $error("word stop");
  a_we16: assert property (p_we16) else $error("half stop");
  a_last: assert property (p_last) else $error("last latch");
  a_nw: assert property (p_nw) else $error("word count");
  a_gap: assert property (p_gap) else $error("read gap");
  a_hit: assert property (p_hit) else $error("hit answer");
endmodule

// file: bench/sdram_model.sv
// Behavioural SDRAM answering read bursts
`timescale 1ns/1ps
module sdram_model
  import sdram_fetch_pkg::*;
(
  input wire logic sd_clk,
  input sd_cmd_s sd_cmd,
  output logic [DQ_W-1:0] sd_dq_in
);
  int tc = 0;
  int cas_tc = -100;
  int stop_tc = -100;
  logic [8:0] col = 9'h000;
  initial sd_dq_in = 16'h0000;
  ////////////////////////////////////////
  always @(negedge sd_clk) begin
    if (!sd_cmd.cas_n) begin
      cas_tc = tc;
      stop_tc = tc + 1000;
      col = sd_cmd.addr[8:0];
    end
    if (!sd_cmd.we_n)
      stop_tc = tc + 2;
  end
  // Released bus toggles so stale data never looks valid
  always @(posedge sd_clk) begin
    tc = tc + 1;
    #1;
    if (tc >= cas_tc + 2 && tc < stop_tc)
      sd_dq_in = 16'({col, 3'(tc - cas_tc - 2)}) ^ 16'ha500;
    else
      sd_dq_in = ~sd_dq_in;
  end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the fetch sequencer
`timescale 1ns/1ps
module testbench
  import sdram_fetch_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  req_s req = '0;
  logic req_ready, rsp_valid, word_valid, busy, sd_clk;
  rsp_s rsp;
  logic [DQ_W-1:0] word_data, sd_dq_in;
  logic [STAT_W-1:0] fill_count, hit_count;
  sd_cmd_s sd_cmd;
  logic cas_q = 1'b1;
  logic [31:0] rnd = 32'h0000b5fd;
  logic [127:0] exp_d;
  int failures = 0, total_checks = 0, cyc = 0, widx = 0, rsp_t = -1;
  int n_fill = 0, n_hit = 0;
  fetch_e last_k;
  req_s q[$];
  int tq[$];
  fetch_e dk[10] = '{FETCH_HIT, FETCH_HIT, FETCH_HALF16, FETCH_FILL32,
    FETCH_FILL16, FETCH_WORD32, FETCH_HALF16, FETCH_WORD32, FETCH_FILL16,
    FETCH_FILL32};
  always #5 clk_sys = ~clk_sys;
  sdram_fetch_seq u_sdram_fetch_seq (.clk_sys, .sys_rst, .req_valid,
    .req_ready, .req, .rsp_valid, .rsp, .word_valid, .word_data, .busy,
    .fill_count, .hit_count, .sd_clk, .sd_cmd, .sd_dq_in);
  sdram_model u_sdram_model (.sd_clk, .sd_cmd, .sd_dq_in);
  ////////////////////////////////////////
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  function automatic req_s mk(input fetch_e k);
    req_s r;
    r.addr = ADDR_W'(xs());
    r.kind = k;
    r.hit_data = xs();
    return r;
  endfunction
  function automatic logic [15:0] wd(input logic [8:0] col, input int j);
    return 16'({col, 3'(j)}) ^ 16'ha500;
  endfunction
  function automatic logic [3:0] nw(input fetch_e k);
    return k == FETCH_HALF16 ? 4'h1 : k inside {FETCH_HIT, FETCH_WORD32} ?
      4'h2 : 4'h8;
  endfunction
  // Clocks from take to response
  function automatic int lat(input fetch_e k);
    return k == FETCH_HIT ? 1 : k == FETCH_WORD32 ? 16 :
      k == FETCH_HALF16 ? 14 : 28;
  endfunction
  task automatic send(input req_s r);
    req <= r;
    req_valid <= 1'b1;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
  endtask
  ////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc++;
    if (req_valid && req_ready) begin
      q.push_back(req);
      tq.push_back(cyc);
    end
    if (word_valid) begin
      check(128'(word_data), 128'(wd(q[0].addr[8:0], widx)));
      widx++;
    end
    if (rsp_valid) begin
      exp_d = '0;
      if (q[0].kind == FETCH_HIT)
        exp_d[31:0] = q[0].hit_data;
      for (int j = 0; j < nw(q[0].kind) && q[0].kind != FETCH_HIT; j++)
        exp_d[16*j +: 16] = wd(q[0].addr[8:0], j);
      check(rsp.data, exp_d);
      check(128'({rsp.hit, rsp.nwords}),
        128'({q[0].kind == FETCH_HIT, nw(q[0].kind)}));
      check(128'(cyc - tq[0]), 128'(lat(q[0].kind)));
      check(128'(widx), q[0].kind == FETCH_HIT ? 128'h0 :
        128'(nw(q[0].kind)));
      if (q[0].kind == FETCH_HIT)
        n_hit++;
      else if (q[0].kind inside {FETCH_FILL32, FETCH_FILL16})
        n_fill++;
      check(128'(hit_count), 128'(n_hit));
      check(128'(fill_count), 128'(n_fill));
      check(128'(busy), 128'(q[0].kind != FETCH_HIT));
      rsp_t = (q[0].kind == FETCH_HIT) ? -1 : cyc;
      last_k = q[0].kind;
      widx = 0;
      void'(q.pop_front());
      void'(tq.pop_front());
    end
    if (cas_q && !sd_cmd.cas_n && rsp_t >= 0)
      check(128'(cyc - rsp_t), (last_k inside {FETCH_FILL16,
        FETCH_HALF16}) ? 128'h0b : 128'h09);
    cas_q = sd_cmd.cas_n;
    if (cyc > 5000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (dk[i]) send(mk(dk[i]));
    repeat (40) send(mk(fetch_e'(3'(xs() % 5))));
    req_valid <= 1'b0;
    repeat (60) @(posedge clk_sys);
    check(128'(busy), 128'h0);
    final_report();
  end
endmodule
bind sdram_fetch_seq sdram_fetch_chk u_sdram_fetch_chk (.clk_sys, .sys_rst,
  .req_valid, .req_ready, .req, .rsp_valid, .rsp, .sd_cmd);
